// >>> hdl/tcpwm_defs.svh
// Register offsets, reset values and bit positions of the compare/PWM timer
`ifndef TCPWM_DEFS_SVH
`define TCPWM_DEFS_SVH
`define TCPWM_OFF_STATUS 4'h0
`define TCPWM_OFF_CNT_HI 4'h1
`define TCPWM_OFF_CNT_LO 4'h2
`define TCPWM_OFF_PER_HI 4'h3
`define TCPWM_OFF_PER_LO 4'h4
`define TCPWM_OFF_CTL0 4'h5
`define TCPWM_OFF_VAL0_HI 4'h6
`define TCPWM_OFF_VAL0_LO 4'h7
`define TCPWM_OFF_CTL1 4'h8
`define TCPWM_OFF_VAL1_HI 4'h9
`define TCPWM_OFF_VAL1_LO 4'ha
`define TCPWM_BIT_FLAG 7
`define TCPWM_BIT_IE 6
`define TCPWM_BIT_HALT 5
`define TCPWM_BIT_CLEAR 4
`define TCPWM_RST_PERIOD 16'hffff
`define TCPWM_RST_VALUE 16'h0000
`define TCPWM_DIV_UNUSED 3'h7
`define TCPWM_ACT_TOGGLE 2'h1
`define TCPWM_ACT_CLEAR 2'h2
`define TCPWM_ACT_SET 2'h3
`endif

// >>> hdl/tcpwm_pkg.sv
// Types shared by the compare/PWM timer and its users
package tcpwm_pkg;
  // Register bus request from the processor side
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tcpwm_bus_t;
  // Channel configuration, bits 6..0 of a channel control register
  typedef struct packed {
    logic ie;
    logic msb;
    logic msa;
    logic [1:0] act;
    logic tov;
    logic max;
  } tcpwm_chcfg_t;
  // Channel pin drive
  typedef struct packed {
    logic ch0_out;
    logic ch0_oe;
    logic ch1_out;
    logic ch1_oe;
  } tcpwm_pins_t;
endpackage

// >>> hdl/tcpwm_top.sv
// Two-channel compare/PWM timer with linked buffered channel
// What this block does
// - Link bit joins both channels into one
// - Last written value set takes over at wrap
// - Linked: only channel0 pin driven, ctl1 unused
// - Toggle on overflow inverts pin at wrap
// - Compare action 10 clears, 11 sets pin
// - Mode 01 unbuffered, 10 buffered
// - Link bit outranks single mode bit
// - No overflow toggle with clear action 10 gives zero duty
// - Full duty force with toggle: constant level
// - Wrap flag set at limit, irq when enabled
// - Channel flag on compare, irq when enabled
// - Runs in wait, bus blocked, irq wakes
// - Stop mode freezes counting and pins, resumes after
// - Count sequence includes the period limit
// - Pulse spans overflow to compare match
// - Compare irq ends pulse, wrap ends period
// - Prescaler divides by 1 to 64, 111 unused
// - Counter restarts from zero after limit
// - Flag clears by read-then-write-zero only
// - Clear bit resets counter, halt set at reset
//
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "tcpwm_defs.svh"
module tcpwm_top #(
  parameter int CW = 16
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire tcpwm_pkg::tcpwm_bus_t bus_req,
  output logic [7:0] rdata,
  input wire logic wait_mode,
  input wire logic stop_mode,
  output tcpwm_pkg::tcpwm_pins_t pins,
  output logic irq_wrap,
  output logic irq_chan0,
  output logic irq_chan1,
  output logic wake_req
);
  import tcpwm_pkg::*;

  // Mask of prescaler bits that must be all ones for a timer tick
  function automatic logic [6:0] div_mask(input logic [2:0] sel);
    logic [6:0] m;
    m = 7'h00;
    for (int i = 0; i < 7; i++) begin
      if (i < int'(sel)) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction

  // Pin update for one channel from overflow and compare events
  function automatic logic pin_upd(input logic cur, input logic wrap,
      input logic match, input tcpwm_chcfg_t cfg);
    logic r;
    r = cur;
    if (cfg.max && cfg.tov) begin
      r = ~cfg.act[0];
    end else begin
      if (wrap && cfg.tov) begin
        r = ~r;
      end
      if (match) begin
        unique case (cfg.act)
          `TCPWM_ACT_TOGGLE: r = ~r;
          `TCPWM_ACT_CLEAR: r = 1'b0;
          `TCPWM_ACT_SET: r = 1'b1;
          default: r = r;
        endcase
      end
    end
    return r;
  endfunction

  // Next value of a software-cleared flag; a new event wins
  function automatic logic flag_upd(input logic flag, input logic arm,
      input logic set, input logic clr_wr);
    return set | (flag & ~(clr_wr & arm));
  endfunction

  // Arming of the read-then-write clear sequence
  function automatic logic arm_upd(input logic arm, input logic set,
      input logic rd_hit, input logic flag, input logic wr_hit);
    logic r;
    r = arm;
    if (set) begin
      r = 1'b0;
    end else if (rd_hit && flag) begin
      r = 1'b1;
    end else if (wr_hit) begin
      r = 1'b0;
    end
    return r;
  endfunction

  // Reset synchroniser; the first stage feeds only the second
  logic rst_meta_reg;
  logic rst_n_reg;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // Register state
  logic wrap_flag_reg, wrap_arm_reg, wrap_ie_reg, halt_reg;
  logic [2:0] div_reg; // Prescaler select
  logic [6:0] psc_reg; // Prescaler
  logic [CW-1:0] cnt_reg, period_reg, val0_reg, val1_reg;
  tcpwm_chcfg_t cfg0_reg, cfg1_reg;
  logic flag0_reg, arm0_reg, flag1_reg, arm1_reg;
  logic act_sel_reg; // Set now steering the linked output
  logic last_sel_reg; // Set written most recently
  logic pin0_reg, pin1_reg;
  logic [7:0] rdata_reg;

  // Bus decode; the processor cannot reach registers in wait
  wire acc_wr = bus_req.wr & ~wait_mode;
  wire acc_rd = bus_req.rd & ~wait_mode;
  wire wr_stat = acc_wr && bus_req.addr == `TCPWM_OFF_STATUS;
  wire rd_stat = acc_rd && bus_req.addr == `TCPWM_OFF_STATUS;
  wire wr_ctl0 = acc_wr && bus_req.addr == `TCPWM_OFF_CTL0;
  wire rd_ctl0 = acc_rd && bus_req.addr == `TCPWM_OFF_CTL0;
  wire linked = cfg0_reg.msb;
  // Control register 1 ignores writes while linked; reads still return its flag and configuration
  wire wr_ctl1 = acc_wr && bus_req.addr == `TCPWM_OFF_CTL1 && !linked;
  wire rd_ctl1 = acc_rd && bus_req.addr == `TCPWM_OFF_CTL1;
  wire wr_v0h = acc_wr && bus_req.addr == `TCPWM_OFF_VAL0_HI;
  wire wr_v0l = acc_wr && bus_req.addr == `TCPWM_OFF_VAL0_LO;
  wire wr_v1h = acc_wr && bus_req.addr == `TCPWM_OFF_VAL1_HI;
  wire wr_v1l = acc_wr && bus_req.addr == `TCPWM_OFF_VAL1_LO;
  wire wr_perh = acc_wr && bus_req.addr == `TCPWM_OFF_PER_HI;
  wire wr_perl = acc_wr && bus_req.addr == `TCPWM_OFF_PER_LO;
  wire wd_flag = bus_req.wdata[`TCPWM_BIT_FLAG];
  wire clear_req = wr_stat & bus_req.wdata[`TCPWM_BIT_CLEAR];

  // Timer tick: stop mode and the halt bit both freeze counting
  wire run = ~halt_reg & ~stop_mode;
  wire psc_hit = ((psc_reg & div_mask(div_reg)) == div_mask(div_reg))
      && div_reg != `TCPWM_DIV_UNUSED;
  wire tick = run & psc_hit;
  // Wrap happens on leaving the limit, so the limit is counted
  wire wrap = tick && cnt_reg == period_reg;
  wire [CW-1:0] cnt_inc = wrap ? '0 : cnt_reg + 1'b1;

  // Channel modes
  wire oc0 = cfg0_reg.msb | cfg0_reg.msa;
  wire oc1 = cfg1_reg.msa & ~linked;
  wire [CW-1:0] cmp0 = (linked && act_sel_reg) ? val1_reg : val0_reg;
  // Compare fires when the count arrives at the value
  wire match0 = tick && oc0 && cnt_inc == cmp0;
  wire match1 = tick && oc1 && cnt_inc == val1_reg;

  // Prescaler and counter; clear wins over halt and stop
  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      psc_reg <= 7'h00;
      cnt_reg <= '0;
    end else if (clear_req) begin
      psc_reg <= 7'h00;
      cnt_reg <= '0;
    end else if (run) begin
      psc_reg <= psc_reg + 7'h01;
      if (tick) begin
        cnt_reg <= cnt_inc;
      end
    end
  end

  // Timer status register; halt comes up set
  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      wrap_ie_reg <= 1'b0;
      halt_reg <= 1'b1;
      div_reg <= 3'h0;
    end else if (wr_stat) begin
      wrap_ie_reg <= bus_req.wdata[`TCPWM_BIT_IE];
      halt_reg <= bus_req.wdata[`TCPWM_BIT_HALT];
      div_reg <= bus_req.wdata[2:0];
    end
  end

  // Sticky event flags with their clear sequences
  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      wrap_flag_reg <= 1'b0;
      wrap_arm_reg <= 1'b0;
      flag0_reg <= 1'b0;
      arm0_reg <= 1'b0;
      flag1_reg <= 1'b0;
      arm1_reg <= 1'b0;
    end else begin
      wrap_flag_reg <= flag_upd(wrap_flag_reg, wrap_arm_reg, wrap,
          wr_stat & ~wd_flag);
      wrap_arm_reg <= arm_upd(wrap_arm_reg, wrap, rd_stat,
          wrap_flag_reg, wr_stat);
      flag0_reg <= flag_upd(flag0_reg, arm0_reg, match0,
          wr_ctl0 & ~wd_flag);
      arm0_reg <= arm_upd(arm0_reg, match0, rd_ctl0, flag0_reg, wr_ctl0);
      flag1_reg <= flag_upd(flag1_reg, arm1_reg, match1,
          wr_ctl1 & ~wd_flag);
      arm1_reg <= arm_upd(arm1_reg, match1, rd_ctl1, flag1_reg, wr_ctl1);
    end
  end

  // Channel configuration and value registers
  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      cfg0_reg <= '0;
      cfg1_reg <= '0;
      period_reg <= `TCPWM_RST_PERIOD;
      val0_reg <= `TCPWM_RST_VALUE;
      val1_reg <= `TCPWM_RST_VALUE;
    end else begin
      if (wr_ctl0) begin
        cfg0_reg <= tcpwm_chcfg_t'(bus_req.wdata[6:0]);
      end
      if (wr_ctl1) begin
        cfg1_reg <= tcpwm_chcfg_t'(bus_req.wdata[6:0]);
      end
      if (wr_perh) period_reg[15:8] <= bus_req.wdata;
      if (wr_perl) period_reg[7:0] <= bus_req.wdata;
      if (wr_v0h) val0_reg[15:8] <= bus_req.wdata;
      if (wr_v0l) val0_reg[7:0] <= bus_req.wdata;
      if (wr_v1h) val1_reg[15:8] <= bus_req.wdata;
      if (wr_v1l) val1_reg[7:0] <= bus_req.wdata;
    end
  end

  // Linked-set tracking; handover waits for a wrap so the
  // running pulse is never cut short by a value written to the other set
  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      act_sel_reg <= 1'b0;
      last_sel_reg <= 1'b0;
    end else if (!linked) begin
      act_sel_reg <= 1'b0;
      last_sel_reg <= 1'b0;
    end else begin
      if (wr_v1h || wr_v1l) begin
        last_sel_reg <= 1'b1;
      end else if (wr_v0h || wr_v0l) begin
        last_sel_reg <= 1'b0;
      end
      if (wrap) begin
        act_sel_reg <= last_sel_reg;
      end
    end
  end

  // Channel pins; a channel not in compare mode holds its level
  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      pin0_reg <= 1'b0;
      pin1_reg <= 1'b0;
    end else begin
      if (oc0 && !stop_mode) begin
        pin0_reg <= pin_upd(pin0_reg, wrap, match0, cfg0_reg);
      end
      if (oc1 && !stop_mode) begin
        pin1_reg <= pin_upd(pin1_reg, wrap, match1, cfg1_reg);
      end
    end
  end

  // Read data mux; the clear bit always reads zero
  logic [7:0] rd_sel;
  always_comb begin
    rd_sel = 8'h00;
    unique case (bus_req.addr)
      `TCPWM_OFF_STATUS: rd_sel = {wrap_flag_reg, wrap_ie_reg, halt_reg,
          1'b0, 1'b0, div_reg};
      `TCPWM_OFF_CNT_HI: rd_sel = cnt_reg[15:8];
      `TCPWM_OFF_CNT_LO: rd_sel = cnt_reg[7:0];
      `TCPWM_OFF_PER_HI: rd_sel = period_reg[15:8];
      `TCPWM_OFF_PER_LO: rd_sel = period_reg[7:0];
      `TCPWM_OFF_CTL0: rd_sel = {flag0_reg, cfg0_reg};
      `TCPWM_OFF_VAL0_HI: rd_sel = val0_reg[15:8];
      `TCPWM_OFF_VAL0_LO: rd_sel = val0_reg[7:0];
      `TCPWM_OFF_CTL1: rd_sel = {flag1_reg, cfg1_reg};
      `TCPWM_OFF_VAL1_HI: rd_sel = val1_reg[15:8];
      `TCPWM_OFF_VAL1_LO: rd_sel = val1_reg[7:0];
      default: rd_sel = 8'h00;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= acc_rd ? rd_sel : 8'h00;
    end
  end

  // Outputs
  assign rdata = rdata_reg;
  assign pins.ch0_out = pin0_reg;
  assign pins.ch0_oe = oc0;
  assign pins.ch1_out = pin1_reg;
  assign pins.ch1_oe = oc1;
  assign irq_wrap = wrap_flag_reg & wrap_ie_reg;
  assign irq_chan0 = flag0_reg & cfg0_reg.ie;
  assign irq_chan1 = flag1_reg & cfg1_reg.ie & ~linked;
  assign wake_req = irq_wrap | irq_chan0 | irq_chan1;

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n_reg);
  sequence wrap_s;
    linked && wrap;
  endsequence
  halt_freeze_a: assert property (halt_reg && !clear_req |=>
      $stable(cnt_reg)) else $error("counter moved while halted");
  clear_zero_a: assert property (clear_req |=>
      cnt_reg == '0 && psc_reg == 7'h00) else $error("clear failed");
  wrap_zero_a: assert property (wrap && !clear_req |=>
      cnt_reg == '0) else $error("no restart after limit");
  wrap_flag_a: assert property (wrap ##1 wrap_ie_reg |->
      irq_wrap) else $error("wrap irq missing");
  chan_irq_a: assert property (match0 && cfg0_reg.ie && !wr_ctl0 |=>
      irq_chan0) else $error("channel irq missing");
  stop_hold_a: assert property (stop_mode && !clear_req |=>
      $stable(cnt_reg) && $stable(pin0_reg)) else $error("stop not held");
  // Stop mode freezes the pin, so the forced level is only checked outside stop mode
  full_duty_a: assert property (oc0 && cfg0_reg.max && cfg0_reg.tov
      && !stop_mode |=> pin0_reg == !$past(cfg0_reg.act[0]))
      else $error("full duty");
  no_tov_a: assert property (oc0 && !cfg0_reg.tov && !match0 |=>
      $stable(pin0_reg)) else $error("pin moved without event");
  act_low_a: assert property (match0 && !cfg0_reg.max &&
      cfg0_reg.act == `TCPWM_ACT_CLEAR |=> !pin0_reg)
      else $error("clear action failed");
  act_high_a: assert property (match0 && !cfg0_reg.max &&
      cfg0_reg.act == `TCPWM_ACT_SET |=> pin0_reg)
      else $error("set action failed");
  link_swap_a: assert property (wrap_s ##1 linked |->
      act_sel_reg == $past(last_sel_reg)) else $error("handover wrong");
  link_pin1_a: assert property (linked |-> !pins.ch1_oe &&
      !irq_chan1) else $error("channel 1 active while linked");
  flag_keep_a: assert property (match0 |=> flag0_reg)
      else $error("event flag lost");
  wait_block_a: assert property (wait_mode && bus_req.wr |=>
      $stable(period_reg)) else $error("write taken in wait");
endmodule

// >>> sim/tcpwm_pin_load.sv
// Board load on both channel pins, read back as wire levels
`timescale 1ns/1ps
module tcpwm_pin_load (
  input wire logic ref_clk,
  input wire tcpwm_pkg::tcpwm_pins_t pins,
  output logic line0,
  output logic line1
);
  import tcpwm_pkg::*;
  // Pull-downs hold a released pin low, so a stale level never shows
  assign line0 = pins.ch0_oe ? pins.ch0_out : 1'b0;
  assign line1 = pins.ch1_oe ? pins.ch1_out : 1'b0;
endmodule

// >>> sim/testbench.sv
// Self-checking bench for the compare/PWM timer
`timescale 1ns/1ps
module testbench;
  import tcpwm_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  tcpwm_bus_t bus_req = '0;
  logic [7:0] rdata;
  logic wait_mode = 1'b0;
  logic stop_mode = 1'b0;
  tcpwm_pins_t pins;
  logic irq_wrap, irq_chan0, irq_chan1, wake_req, line0, line1;
  int num_errors = 0;
  int tests_run = 0;
  // Reset rows: {index, expected byte}; index b and f are unmapped
  logic [11:0] rows [13] = '{12'h020, 12'h100, 12'h200, 12'h3ff,
    12'h4ff, 12'h500, 12'h600, 12'h700, 12'h800, 12'h900, 12'ha00,
    12'hb00, 12'hf00};
  logic [7:0] a, b;
  int h;
  tcpwm_top #(.CW(16)) dut_u (.ref_clk(ref_clk), .reset_n(reset_n),
    .bus_req(bus_req), .rdata(rdata), .wait_mode(wait_mode),
    .stop_mode(stop_mode), .pins(pins), .irq_wrap(irq_wrap),
    .irq_chan0(irq_chan0), .irq_chan1(irq_chan1), .wake_req(wake_req));
  tcpwm_pin_load load_u (.ref_clk(ref_clk), .pins(pins),
    .line0(line0), .line1(line1));
  // Free-running bus clock
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic tally_and_finish;
    $display("errors %0d of %0d checks", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Byte, bit and count comparisons
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected at %0t: byte %h not %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected at %0t: bit %b not %b", $time, g, e);
    end
  endtask
  task automatic chkn(input int g, input int e);
    tests_run++;
    if (g != e) begin
      num_errors++;
      $display("unexpected at %0t: count %0d not %0d", $time, g, e);
    end
  endtask
  // One-cycle write strobe
  task automatic wr(input logic [3:0] ad, input logic [7:0] d);
    @(posedge ref_clk);
    bus_req <= '{addr: ad, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus_req.wr <= 1'b0;
  endtask
  // Read strobe; data stand only in the following cycle
  task automatic rd(input logic [3:0] ad, output logic [7:0] d);
    @(posedge ref_clk);
    bus_req <= '{addr: ad, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus_req.rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  // High cycles on channel0 line over n cycles, optionally from a rise
  task automatic meas(input bit sync, input int n, output int hi);
    logic p;
    p = 1'b1;
    hi = 0;
    for (int i = 0; sync && i < 3000 && !(p === 1'b0 && line0 === 1'b1);
      i++) begin
      p = line0;
      @(posedge ref_clk);
      #1;
    end
    for (int i = 0; i < n; i++) begin
      if (line0 === 1'b1) hi++;
      @(posedge ref_clk);
      #1;
    end
  endtask
  // Cuts a hang short; the whole run needs about 6000 cycles
  initial begin
    repeat (60000) @(posedge ref_clk);
    num_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
    for (int i = 0; i < 13; i++) begin
      rd(rows[i][11:8], a);
      chk8(a, rows[i][7:0]);
    end
    // Initialisation order: halt and clear, period, width, mode, run
    wr(4'h0, 8'h30);
    rd(4'h2, a);
    chk8(a, 8'h00);
    rd(4'h0, a);
    chk8(a, 8'h20);
    wr(4'h3, 8'h00);
    wr(4'h4, 8'hff);
    wr(4'h7, 8'h80);
    wr(4'h5, 8'h1a);
    wr(4'h0, 8'h00);
    meas(1, 512, h);
    chkn(h, 256);
    chk1(pins.ch0_oe, 1'b1);
    // Shorter width is written only once the running pulse has ended
    for (int i = 0; i < 600 && line0 !== 1'b0; i++) begin
      @(posedge ref_clk);
      #1;
    end
    wr(4'h7, 8'h40);
    // Set on compare inverts the pulse: low from wrap to match
    wr(4'h5, 8'h1e);
    // One full period first, so the action change has settled
    repeat (300) @(posedge ref_clk);
    meas(1, 512, h);
    chkn(h, 384);
    wr(4'h5, 8'h1a);
    rd(4'h5, a);
    chk8(a & 8'h80, 8'h80);
    // Halted, then a read followed by a write of zero clears the flag
    wr(4'h0, 8'h20);
    rd(4'h0, a);
    chk8(a, 8'ha0);
    wr(4'h0, 8'h20);
    rd(4'h0, a);
    chk8(a, 8'h20);
    wr(4'h0, 8'h00);
    stop_mode <= 1'b1;
    rd(4'h2, a);
    repeat (20) @(posedge ref_clk);
    rd(4'h2, b);
    chk8(b, a);
    @(posedge ref_clk);
    stop_mode <= 1'b0;
    repeat (5) @(posedge ref_clk);
    rd(4'h2, b);
    chk1(b !== a, 1'b1);
    // Wait mode blocks the bus, but the timer still raises its request
    wr(4'h0, 8'h40);
    wait_mode <= 1'b1;
    wr(4'h3, 8'h12);
    rd(4'h0, a);
    chk8(a, 8'h00);
    for (int i = 0; i < 600 && irq_wrap !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
    chk1(irq_wrap, 1'b1);
    chk1(wake_req, 1'b1);
    chk1(irq_chan0, 1'b0);
    @(posedge ref_clk);
    wait_mode <= 1'b0;
    // The period write made during wait must not have landed
    rd(4'h3, a);
    chk8(a, 8'h00);
    // Divide by 4: one quarter-duty pulse fills 256 of 512 cycles
    wr(4'h0, 8'h02);
    meas(1, 512, h);
    chkn(h, 256);
    wr(4'h0, 8'h07);
    rd(4'h2, a);
    repeat (10) @(posedge ref_clk);
    rd(4'h2, b);
    chk8(b, a);
    wr(4'h0, 8'h00);
    // No overflow toggle: the compare only drives the level it has
    wr(4'h5, 8'h58);
    repeat (600) @(posedge ref_clk);
    meas(0, 256, h);
    chkn(h, 0);
    chk1(irq_chan0, 1'b1);
    wr(4'h5, 8'h1b);
    // Channel 1 at full duty with its interrupt on, before linking
    wr(4'h8, 8'h5b);
    repeat (3) @(posedge ref_clk);
    meas(0, 256, h);
    chkn(h, 256);
    chk1(line1, 1'b1);
    chk1(irq_chan1, 1'b1);
    // Both mode bits set: the link bit decides
    wr(4'h5, 8'h3a);
    wr(4'ha, 8'h60);
    chk1(line1, 1'b0);
    chk1(pins.ch1_oe, 1'b0);
    meas(1, 512, h);
    chkn(h, 192);
    wr(4'h7, 8'h20);
    meas(1, 512, h);
    chkn(h, 64);
    rd(4'h5, a);
    chk8(a & 8'h80, 8'h80);
    wr(4'h8, 8'h5a);
    rd(4'h8, a);
    chk8(a, 8'hdb);
    chk1(irq_chan1, 1'b0);
    tally_and_finish();
  end
endmodule
